// >>> logic/interlock_diag.sv
`timescale 1ns/1ps
module interlock_diag import interlock_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int WARN_LEN    = WARN_TICKS,
  parameter int LOCK_LIMIT  = LOCK_LIFE,
  parameter int ACT_LIMIT   = ACT_LIFE,
  parameter int CNT_W       = 20
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        LOCK_CMD,
  input  wire logic        DOOR_CLOSED,
  input  wire logic        ACTUATOR_OK,
  input  wire logic        BOLT_LOCKED,
  input  wire logic        SAFETY_OUTPUT_A_FAULT,
  input  wire logic        SAFETY_OUTPUT_B_FAULT,
  input  wire logic        CROSS_SHORT,
  input  wire logic        OVER_TEMP,
  input  wire logic        ACTUATOR_FAULT,
  input  wire logic        CTRL_INPUT_FAULT,
  input  wire logic        LOCK_MECH_FAULT,
  input  wire logic        SUPPLY_FAULT,
  input  wire logic        DEVICE_DEFECT,
  output logic             SAFETY_OUTPUT_A,
  output logic             SAFETY_OUTPUT_B,
  output logic             DIAG_OUT,
  output logic             LOCK_DRIVE,
  output logic             LED_GREEN,
  output logic             LED_RED,
  output logic             LED_YELLOW,
  output logic             IRQ,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int WW = $clog2(WARN_LEN + 1);

  // timebase
  logic [TW-1:0] tick_cnt_r;
  logic          tick_r;
  logic [8:0]    blink_cnt_r;
  logic          blink_r;
  wire           tick_wrap = (tick_cnt_r == TW'(TICK_CYCLES - 1));
  wire           blink_wrap = tick_r && (blink_cnt_r == 9'(BLINK_HALF_MS - 1));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_r  <= '0;
      tick_r      <= 1'b0;
      blink_cnt_r <= 9'h000;
      blink_r     <= 1'b0;
    end else begin
      tick_cnt_r  <= tick_wrap ? '0 : tick_cnt_r + TW'(1);
      tick_r      <= tick_wrap;
      blink_cnt_r <= blink_wrap ? 9'h000 : (tick_r ? blink_cnt_r + 9'h001 : blink_cnt_r);
      blink_r     <= blink_wrap ? ~blink_r : blink_r;
    end
  end

  // fault classification
  wire        both_fault = (SAFETY_OUTPUT_A_FAULT && SAFETY_OUTPUT_B_FAULT) || CROSS_SHORT;
  wire        warn_cause = SAFETY_OUTPUT_A_FAULT || SAFETY_OUTPUT_B_FAULT || CROSS_SHORT ||
                           OVER_TEMP || SUPPLY_FAULT;
  wire        imm_fault  = ACTUATOR_FAULT || CTRL_INPUT_FAULT || LOCK_MECH_FAULT || DEVICE_DEFECT;
  wire [3:0]  warn_code  = both_fault            ? CODE_CROSS :
                           SAFETY_OUTPUT_A_FAULT ? CODE_OUT_A :
                           SAFETY_OUTPUT_B_FAULT ? CODE_OUT_B :
                           OVER_TEMP             ? CODE_TEMP  : CODE_SUPPLY;
  wire [3:0]  imm_code   = DEVICE_DEFECT   ? CODE_DEFECT :
                           LOCK_MECH_FAULT ? CODE_MECH :
                           CTRL_INPUT_FAULT ? CODE_CTRL : CODE_ACT;

  door_t            state_r;
  logic             warn_r, err_r, lockout_r, life_r;
  logic [WW-1:0]    warn_cnt_r;
  logic [3:0]       err_code_r, shown_code_r;
  logic [CNT_W-1:0] lock_cnt_r, act_cnt_r;
  logic             bolt_q_r, act_q_r, safe_r;

  wire        warn_expire = warn_r && warn_cause && tick_r && (warn_cnt_r == WW'(WARN_LEN - 1));
  wire        err_set     = imm_fault || warn_expire;
  // set wins over clear; a lockout blocks the normal acknowledge
  wire        err_clear   = !DOOR_CLOSED && !imm_fault && !warn_cause && !lockout_r;
  wire        err_nxt     = err_set || (err_r && !err_clear);
  wire        warn_nxt    = warn_cause && !err_set && !err_r;
  wire [3:0]  err_code_nxt = imm_fault ? imm_code : (warn_expire ? warn_code : err_code_r);
  wire        lock_rise   = BOLT_LOCKED && !bolt_q_r;
  wire        act_now     = DOOR_CLOSED && ACTUATOR_OK;
  wire        act_rise    = act_now && !act_q_r;
  wire        life_nxt    = life_r || (lock_cnt_r >= CNT_W'(LOCK_LIMIT)) ||
                            (act_cnt_r >= CNT_W'(ACT_LIMIT));
  door_t      state_nxt;
  assign state_nxt = !DOOR_CLOSED ? ST_OPEN :
                     (BOLT_LOCKED && ACTUATOR_OK) ? ST_LOCKED : ST_CLOSED;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r    <= ST_OPEN;
      warn_r     <= 1'b0;
      err_r      <= 1'b0;
      lockout_r  <= 1'b0;
      life_r     <= 1'b0;
      warn_cnt_r <= '0;
      err_code_r <= CODE_NONE;
      lock_cnt_r <= '0;
      act_cnt_r  <= '0;
      bolt_q_r   <= 1'b0;
      act_q_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      warn_r     <= warn_nxt;
      err_r      <= err_nxt;
      lockout_r  <= lockout_r || both_fault;
      life_r     <= life_nxt;
      warn_cnt_r <= !warn_r ? '0 : (tick_r ? warn_cnt_r + WW'(1) : warn_cnt_r);
      err_code_r <= err_code_nxt;
      bolt_q_r   <= BOLT_LOCKED;
      act_q_r    <= act_now;
      // counters saturate at the limit, so a stuck input cannot wrap them
      if (lock_rise && lock_cnt_r < CNT_W'(LOCK_LIMIT))
        lock_cnt_r <= lock_cnt_r + CNT_W'(1);
      if (act_rise && act_cnt_r < CNT_W'(ACT_LIMIT))
        act_cnt_r  <= act_cnt_r + CNT_W'(1);
    end
  end

  // output mapping
  wire        run_ok    = !err_r && !life_r;
  // a warning never enables outputs that were off, it only keeps them
  wire        safe_nxt  = run_ok && (state_r == ST_LOCKED) && (safe_r || !warn_r);
  wire        diag_nxt  = run_ok && !warn_nxt && !err_nxt && (state_r != ST_OPEN) &&
                          !((state_r == ST_CLOSED) && !LOCK_CMD);
  wire        lock_nxt  = !LOCK_CMD && act_now && !life_r;
  wire [3:0]  code_nxt  = err_r ? err_code_r : (warn_r ? warn_code : CODE_NONE);
  wire        flash_red;
  logic       yellow_nxt;

  always_comb begin
    yellow_nxt = 1'b0;
    unique case (state_r)
      ST_OPEN:   yellow_nxt = 1'b0;
      ST_CLOSED: yellow_nxt = blink_r;
      ST_LOCKED: yellow_nxt = warn_r ? blink_r : 1'b1;
    endcase
    if (life_r)
      yellow_nxt = 1'b0;
  end

  flash_code_gen u_flash (
    .clk   (CLK),
    .rst_n (RST_N),
    .tick  (tick_r),
    .code  (shown_code_r),
    .red   (flash_red)
  );

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      safe_r       <= 1'b0;
      DIAG_OUT     <= 1'b0;
      LOCK_DRIVE   <= 1'b0;
      LED_GREEN    <= 1'b0;
      LED_RED      <= 1'b0;
      LED_YELLOW   <= 1'b0;
      shown_code_r <= CODE_NONE;
    end else begin
      safe_r       <= safe_nxt;
      DIAG_OUT     <= diag_nxt;
      LOCK_DRIVE   <= lock_nxt;
      LED_GREEN    <= life_r ? blink_r : 1'b1;
      LED_RED      <= life_r ? !blink_r : flash_red;
      LED_YELLOW   <= yellow_nxt;
      shown_code_r <= code_nxt;
    end
  end
  assign SAFETY_OUTPUT_A = safe_r;
  assign SAFETY_OUTPUT_B = safe_r;

  // events and interrupt
  logic [EV_W-1:0] evt_r, mask_r;
  wire  [EV_W-1:0] ev_set = {lock_rise, life_nxt && !life_r, both_fault && !lockout_r,
                             err_nxt && !err_r, warn_nxt && !warn_r};

  // AXI4-Lite slave
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_got_r, w_got_r;
  wire         aw_take  = AWVALID && AWREADY;
  wire         w_take   = WVALID && WREADY;
  wire         wr_fire  = aw_got_r && w_got_r && !BVALID;
  wire         aw_got_nxt = aw_got_r ? !wr_fire : aw_take;
  wire         w_got_nxt  = w_got_r ? !wr_fire : w_take;
  wire         bvalid_nxt = wr_fire || (BVALID && !BREADY);
  wire         ar_take  = ARVALID && ARREADY;
  wire         rvalid_nxt = ar_take || (RVALID && !RREADY);
  wire         wr_event = wr_fire && (awaddr_r == OFF_EVENT) && wstrb_r[0];
  wire         wr_mask  = wr_fire && (awaddr_r == OFF_MASK) && wstrb_r[0];
  wire         wr_hit   = (awaddr_r == OFF_STATUS) || (awaddr_r == OFF_EVENT) || (awaddr_r == OFF_MASK) ||
                          (awaddr_r == OFF_LOCK_CNT) || (awaddr_r == OFF_ACT_CNT);
  wire  [EV_W-1:0] evt_clr = wr_event ? wdata_r[EV_W-1:0] : '0;
  wire  [EV_W-1:0] evt_nxt = ev_set | (evt_r & ~evt_clr);
  wire  [31:0] status_word = {18'h00000, DIAG_OUT, safe_r, shown_code_r, 2'h0, life_r, lockout_r,
                              err_r, warn_r, 2'(state_r)};
  wire         rd_hit   = (ARADDR == OFF_STATUS) || (ARADDR == OFF_EVENT) || (ARADDR == OFF_MASK) ||
                          (ARADDR == OFF_LOCK_CNT) || (ARADDR == OFF_ACT_CNT);
  wire  [31:0] rd_mux   = (ARADDR == OFF_STATUS)   ? status_word :
                          (ARADDR == OFF_EVENT)    ? 32'(evt_r) :
                          (ARADDR == OFF_MASK)     ? 32'(mask_r) :
                          (ARADDR == OFF_LOCK_CNT) ? 32'(lock_cnt_r) :
                          (ARADDR == OFF_ACT_CNT)  ? 32'(act_cnt_r) : 32'h00000000;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
      AWREADY  <= 1'b0;
      WREADY   <= 1'b0;
      BVALID   <= 1'b0;
      BRESP    <= RESP_OKAY;
      ARREADY  <= 1'b0;
      RVALID   <= 1'b0;
      RRESP    <= RESP_OKAY;
      RDATA    <= 32'h00000000;
      evt_r    <= '0;
      mask_r   <= MASK_RST;
      IRQ      <= 1'b0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      if (aw_take)
        awaddr_r <= AWADDR;
      if (w_take) begin
        wdata_r <= WDATA;
        wstrb_r <= WSTRB;
      end
      AWREADY <= !aw_got_nxt && !bvalid_nxt;
      WREADY  <= !w_got_nxt && !bvalid_nxt;
      BVALID  <= bvalid_nxt;
      if (wr_fire)
        BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      ARREADY <= !rvalid_nxt;
      RVALID  <= rvalid_nxt;
      if (ar_take) begin
        RDATA <= rd_mux;
        RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      evt_r <= evt_nxt;
      if (wr_mask)
        mask_r <= wdata_r[EV_W-1:0];
      IRQ <= |(evt_r & mask_r);
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_door_open;
    state_r == ST_OPEN;
  endsequence
  sequence s_outputs_dark;
    !SAFETY_OUTPUT_A && !SAFETY_OUTPUT_B && !LED_YELLOW;
  endsequence

  property p_warn_diag_low;
    warn_r |-> !DIAG_OUT;
  endproperty
  a_warn_diag_low: assert property (p_warn_diag_low) else $error("diag output high during warning");

  property p_err_outputs_off;
    err_r |=> !SAFETY_OUTPUT_A && !SAFETY_OUTPUT_B;
  endproperty
  a_err_outputs_off: assert property (p_err_outputs_off) else $error("safety outputs on after error");

  property p_actuator_immediate;
    ACTUATOR_FAULT |=> err_r ##1 !SAFETY_OUTPUT_A;
  endproperty
  a_actuator_immediate: assert property (p_actuator_immediate) else $error("actuator fault not immediate");

  property p_ctrl_code;
    (CTRL_INPUT_FAULT && !LOCK_MECH_FAULT && !DEVICE_DEFECT) |=> err_r && err_code_r == CODE_CTRL;
  endproperty
  a_ctrl_code: assert property (p_ctrl_code) else $error("control input fault not coded six");

  property p_mech_code;
    (LOCK_MECH_FAULT && !DEVICE_DEFECT) |=> err_r && err_code_r == CODE_MECH;
  endproperty
  a_mech_code: assert property (p_mech_code) else $error("mechanism fault not coded seven");

  property p_lockout_sticky;
    lockout_r |=> lockout_r && !$fell(err_r);
  endproperty
  a_lockout_sticky: assert property (p_lockout_sticky) else $error("lockout released");

  property p_life_end;
    life_r |=> !SAFETY_OUTPUT_A && !DIAG_OUT && !LOCK_DRIVE && (LED_GREEN != LED_RED);
  endproperty
  a_life_end: assert property (p_life_end) else $error("service life end not enforced");

  property p_err_clear_open;
    $fell(err_r) |-> !$past(DOOR_CLOSED);
  endproperty
  a_err_clear_open: assert property (p_err_clear_open) else $error("error cleared with door closed");

  property p_open_dark;
    s_door_open |=> s_outputs_dark;
  endproperty
  a_open_dark: assert property (p_open_dark) else $error("outputs lit with door open");

  property p_lock_cmd;
    (!LOCK_CMD && DOOR_CLOSED && ACTUATOR_OK && !life_r) |=> LOCK_DRIVE;
  endproperty
  a_lock_cmd: assert property (p_lock_cmd) else $error("lock not driven");

  property p_defect_red;
    (shown_code_r == CODE_DEFECT && !life_r) [*3] |=> LED_RED;
  endproperty
  a_defect_red: assert property (p_defect_red) else $error("defect red not steady");

  property p_out_a_code;
    (warn_r && !err_r && SAFETY_OUTPUT_A_FAULT && !both_fault) |=> shown_code_r == CODE_OUT_A || err_r;
  endproperty
  a_out_a_code: assert property (p_out_a_code) else $error("output A warning not coded one");
endmodule

// >>> logic/interlock_pkg.sv
// Functional notes
// - output A fault warns, one flash, 30 min
// - output B fault warns, two flashes, delayed
// - cross short or both faults, three flashes
// - overtemperature warns, four flashes, delayed
// - bad actuator, five flashes, immediate off
// - control input error, six flashes, immediate
// - lock mechanism blocked, seven flashes, immediate
// - supply out of range, eight flashes, delayed
// - warning keeps outputs only 30 minutes
// - service life reached: no lock, alternate
// - lock command low with actuator locks
// - any warning drops diagnostic output at once
// - latched error clears only on door open
// - output double fault latches until power cycle
package interlock_pkg;

  localparam int CLK_HZ         = 40_000_000;
  localparam int TICK_MS        = 1;
  localparam int TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
  localparam int WARN_MIN       = 30;
  localparam int WARN_TICKS     = WARN_MIN * 60_000 / TICK_MS;
  localparam int FLASH_ON_MS    = 200;
  localparam int FLASH_OFF_MS   = 300;
  localparam int FLASH_PAUSE_MS = 1500;
  localparam int BLINK_HALF_MS  = 500;
  localparam int LOCK_LIFE      = 1_000_000;
  localparam int ACT_LIFE       = 500_000;

  localparam logic [3:0] CODE_NONE    = 4'h0;
  localparam logic [3:0] CODE_OUT_A   = 4'h1;
  localparam logic [3:0] CODE_OUT_B   = 4'h2;
  localparam logic [3:0] CODE_CROSS   = 4'h3;
  localparam logic [3:0] CODE_TEMP    = 4'h4;
  localparam logic [3:0] CODE_ACT     = 4'h5;
  localparam logic [3:0] CODE_CTRL    = 4'h6;
  localparam logic [3:0] CODE_MECH    = 4'h7;
  localparam logic [3:0] CODE_SUPPLY  = 4'h8;
  localparam logic [3:0] CODE_DEFECT  = 4'hf;

  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_EVENT    = 8'h04;
  localparam logic [7:0] OFF_MASK     = 8'h08;
  localparam logic [7:0] OFF_LOCK_CNT = 8'h0c;
  localparam logic [7:0] OFF_ACT_CNT  = 8'h10;

  localparam int EV_W       = 5;
  localparam int EV_WARN    = 0;
  localparam int EV_ERR     = 1;
  localparam int EV_LOCKOUT = 2;
  localparam int EV_LIFE    = 3;
  localparam int EV_LOCK    = 4;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;

  localparam int ST_F_STATE   = 0;
  localparam int ST_F_WARN    = 2;
  localparam int ST_F_ERR     = 3;
  localparam int ST_F_LOCKOUT = 4;
  localparam int ST_F_LIFE    = 5;
  localparam int ST_F_CODE    = 8;
  localparam int ST_F_SAFE    = 12;
  localparam int ST_F_DIAG    = 13;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_OPEN, ST_CLOSED, ST_LOCKED} door_t;

endpackage

// >>> logic/flash_code_gen.sv
`timescale 1ns/1ps
module flash_code_gen import interlock_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic [3:0] code,
  output logic            red
);
  typedef enum logic [1:0] {PH_ON, PH_OFF, PH_PAUSE} phase_t;

  phase_t      phase_r, phase_nxt;
  logic [10:0] ms_r, ms_nxt;
  logic [3:0]  pulse_r, pulse_nxt;
  logic [3:0]  code_r;
  logic        red_nxt;
  wire  [10:0] phase_len = (phase_r == PH_ON)  ? 11'(FLASH_ON_MS) :
                           (phase_r == PH_OFF) ? 11'(FLASH_OFF_MS) : 11'(FLASH_PAUSE_MS);
  wire         phase_end = tick && (ms_r == phase_len - 11'h001);

  always_comb begin
    phase_nxt = phase_r;
    ms_nxt    = tick ? ms_r + 11'h001 : ms_r;
    pulse_nxt = pulse_r;
    if (code != code_r) begin
      // a new code restarts the sequence so no partial count is shown
      phase_nxt = PH_ON;
      ms_nxt    = 11'h000;
      pulse_nxt = 4'h0;
    end else if (phase_end) begin
      ms_nxt = 11'h000;
      unique case (phase_r)
        PH_ON:    phase_nxt = PH_OFF;
        PH_OFF: begin
          if (pulse_r + 4'h1 == code) begin
            phase_nxt = PH_PAUSE;
            pulse_nxt = 4'h0;
          end else begin
            phase_nxt = PH_ON;
            pulse_nxt = pulse_r + 4'h1;
          end
        end
        PH_PAUSE: phase_nxt = PH_ON;
      endcase
    end
    red_nxt = (code == CODE_DEFECT) || ((code != CODE_NONE) && (phase_nxt == PH_ON));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= PH_ON;
      ms_r    <= 11'h000;
      pulse_r <= 4'h0;
      code_r  <= 4'h0;
      red     <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      ms_r    <= ms_nxt;
      pulse_r <= pulse_nxt;
      code_r  <= code;
      red     <= red_nxt;
    end
  end
endmodule

// >>> sim/monitor_model.sv
`timescale 1ns/1ps
module monitor_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic release_req,
  input  wire logic slow,
  input  wire logic out_a,
  input  wire logic out_b,
  input  wire logic diag,
  output logic      lock_cmd,
  output logic      run_ok
);
  logic stage_r;
  // released after reset: a controller never asks for a lock before it is up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_r  <= 1'b1;
      lock_cmd <= 1'b1;
    end else begin
      stage_r  <= release_req;
      lock_cmd <= slow ? stage_r : release_req;
    end
  end
  // diag low while outputs stay on means stop the process in a controlled way
  assign run_ok = out_a & out_b & diag;
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, g, e); end end
module testbench import interlock_pkg::*;;
  logic        clk = 1'b0, rst_n = 1'b0, rel = 1'b1, slow = 1'b0;
  logic        door = 1'b0, act_ok = 1'b0, bolt = 1'b0;
  logic [8:0]  flt = 9'h000;
  logic        lock_cmd, run_ok, out_a, out_b, diag, lock_drv, grn, red, yel, irq;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  int          mismatches = 0, tests_run = 0, cyc = 0;

  interlock_diag #(.TICK_CYCLES(4), .WARN_LEN(20), .LOCK_LIMIT(12), .ACT_LIMIT(12)) u_interlock_diag (
    .CLK(clk), .RST_N(rst_n), .LOCK_CMD(lock_cmd), .DOOR_CLOSED(door), .ACTUATOR_OK(act_ok),
    .BOLT_LOCKED(bolt), .SAFETY_OUTPUT_A_FAULT(flt[0]), .SAFETY_OUTPUT_B_FAULT(flt[1]),
    .CROSS_SHORT(flt[2]), .OVER_TEMP(flt[3]), .ACTUATOR_FAULT(flt[4]), .CTRL_INPUT_FAULT(flt[5]),
    .LOCK_MECH_FAULT(flt[6]), .SUPPLY_FAULT(flt[7]), .DEVICE_DEFECT(flt[8]), .SAFETY_OUTPUT_A(out_a),
    .SAFETY_OUTPUT_B(out_b), .DIAG_OUT(diag), .LOCK_DRIVE(lock_drv), .LED_GREEN(grn), .LED_RED(red),
    .LED_YELLOW(yel), .IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
    .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready));

  monitor_model u_monitor_model (.clk(clk), .rst_n(rst_n), .release_req(rel), .slow(slow),
    .out_a(out_a), .out_b(out_b), .diag(diag), .lock_cmd(lock_cmd), .run_ok(run_ok));

  always #12.5 clk = ~clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // whole run needs about 18k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    tick(16);
    rst_n <= 1'b1;
    tick(2);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // the bench plays the bolt mechanism and sets the bolt six cycles after the lock request
  task automatic close_lock();
    door <= 1'b1;
    act_ok <= 1'b1;
    rel <= 1'b0;
    tick(6);
    bolt <= 1'b1;
    tick(4);
  endtask

  task automatic open_door();
    rel <= 1'b1;
    tick(4);
    bolt <= 1'b0;
    door <= 1'b0;
    tick(4);
  endtask

  task automatic clear_err();
    flt <= 9'h000;
    tick(3);
    rd_reg(OFF_STATUS);
    `CHK(rd[ST_F_ERR], 1'b1)
    open_door();
    rd_reg(OFF_STATUS);
    `CHK(rd[ST_F_ERR], 1'b0)
  endtask

  task automatic t_lock();
    // lock request with the door closed but no valid actuator must not drive the bolt
    door <= 1'b1;
    rel <= 1'b0;
    tick(4);
    `CHK(lock_drv, 1'b0)
    close_lock();
    `CHK(lock_drv, 1'b1)
    `CHK({out_a, out_b, diag, grn, yel, red}, 6'h3e)
    rd_reg(OFF_STATUS);
    `CHK(rd[1:0], ST_LOCKED)
    rel <= 1'b1;
    slow <= 1'b1;
    tick(6);
    `CHK(lock_drv, 1'b0)
    bolt <= 1'b0;
    tick(4);
    `CHK({out_a, out_b}, 2'h0)
    slow <= 1'b0;
    open_door();
    `CHK({out_a, out_b, diag, yel}, 4'h0)
    $display("test lock done");
  endtask

  task automatic t_warn();
    int         idx[4] = '{0, 1, 3, 7};
    logic [3:0] code[4] = '{CODE_OUT_A, CODE_OUT_B, CODE_TEMP, CODE_SUPPLY};
    close_lock();
    foreach (idx[i]) begin
      flt[idx[i]] <= 1'b1;
      tick(3);
      `CHK({diag, run_ok, out_a, out_b}, 4'h3)
      rd_reg(OFF_STATUS);
      `CHK(rd[ST_F_CODE +: 4], code[i])
      flt <= 9'h000;
      tick(3);
      `CHK(diag, 1'b1)
    end
    flt[3] <= 1'b1;
    tick(70);
    `CHK(out_a, 1'b1)
    tick(25);
    `CHK({out_a, out_b}, 2'h0)
    clear_err();
    $display("test warning done");
  endtask

  task automatic t_immed();
    int         idx[4] = '{4, 5, 6, 8};
    logic [3:0] code[4] = '{CODE_ACT, CODE_CTRL, CODE_MECH, CODE_DEFECT};
    foreach (idx[i]) begin
      close_lock();
      flt[idx[i]] <= 1'b1;
      tick(3);
      `CHK({out_a, out_b}, 2'h0)
      rd_reg(OFF_STATUS);
      `CHK(rd[ST_F_CODE +: 4], code[i])
      // a pulse code would be dark within 1200 cycles
      if (idx[i] == 8) repeat (4) begin
        tick(300);
        `CHK(red, 1'b1)
      end
      clear_err();
    end
    $display("test immediate done");
  endtask

  task automatic t_irq();
    rd_reg(OFF_MASK);
    `CHK(rd[4:0], MASK_RST)
    close_lock();
    wr(OFF_EVENT, 32'h1f);
    wr(OFF_MASK, 32'h1);
    flt[7] <= 1'b1;
    tick(4);
    `CHK(irq, 1'b1)
    rd_reg(OFF_EVENT);
    `CHK(rd[EV_WARN], 1'b1)
    flt <= 9'h000;
    tick(3);
    wr(OFF_EVENT, 32'h1);
    tick(3);
    `CHK(irq, 1'b0)
    wr(OFF_MASK, 32'h0);
    flt[7] <= 1'b1;
    tick(4);
    `CHK(irq, 1'b0)
    flt <= 9'h000;
    rd_reg(8'h40);
    `CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
    wr(8'h40, 32'h1);
    `CHK(rsp, RESP_SLVERR)
    open_door();
    $display("test interrupt done");
  endtask

  task automatic t_lockout();
    int   n, per;
    logic prev;
    per = (3 * (FLASH_ON_MS + FLASH_OFF_MS) + FLASH_PAUSE_MS) * 4;
    n = 0;
    close_lock();
    flt[2] <= 1'b1;
    tick(3);
    `CHK({diag, out_a}, 2'h1)
    rd_reg(OFF_STATUS);
    `CHK({rd[ST_F_LOCKOUT], rd[ST_F_CODE +: 4]}, 5'h13)
    tick(100);
    prev = red;
    repeat (per) begin
      @(posedge clk);
      if (red && !prev) n++;
      prev = red;
    end
    `CHK(n, 3)
    flt <= 9'h000;
    open_door();
    rd_reg(OFF_STATUS);
    `CHK({rd[ST_F_LOCKOUT], rd[ST_F_ERR]}, 2'h3)
    do_reset();
    rd_reg(OFF_STATUS);
    `CHK(rd[ST_F_LOCKOUT], 1'b0)
    // faults on both outputs latch the same lockout as a cross short
    flt <= 9'h003;
    tick(3);
    rd_reg(OFF_STATUS);
    `CHK({rd[ST_F_LOCKOUT], rd[ST_F_CODE +: 4]}, 5'h13)
    flt <= 9'h000;
    do_reset();
    $display("test lockout done");
  endtask

  task automatic t_life();
    int n;
    n = 0;
    repeat (12) begin
      close_lock();
      open_door();
    end
    close_lock();
    rd_reg(OFF_STATUS);
    `CHK(rd[ST_F_LIFE], 1'b1)
    `CHK({lock_drv, out_a, out_b, diag, yel}, 5'h0)
    repeat (8) begin
      tick(BLINK_HALF_MS);
      `CHK(grn ^ red, 1'b1)
      n += int'(grn);
    end
    `CHK(n inside {[2:6]}, 1'b1)
    $display("test service life done");
  endtask

  initial begin
    do_reset();
    t_lock();
    t_warn();
    t_immed();
    t_irq();
    t_lockout();
    t_life();
    report_and_stop();
  end
endmodule
